// File: inc/wct_pkg.sv
// Package for the channel-access timing block: types and constants
package wct_pkg;
    localparam int NUM_AC = 4;
    localparam int CNT_W = 16;
    localparam int TSF_W = 64;
    localparam int NAV_W = 16;
    localparam int NUM_TRIG = 2;
    // Slot and microsecond times in ns, cycles derived at 100 MHz
    localparam int CLK_NS = 10;
    localparam int SLOT_NS = 9000;
    localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int US_NS = 1000;
    localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
    // Reset values
    localparam logic [CNT_W-1:0] SIFS_RST = 16'h0640;
    localparam logic [CNT_W-1:0] RIFS_RST = 16'h00c8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [TSF_W-1:0] TSF_ZERO = 64'h0;
    localparam logic [TSF_W-1:0] BCN_RST = 64'h0000_0000_0001_9000;

    // Conflict resolution policy
    typedef enum logic [1:0] {
        WCT_POL_HIGH_AC,
        WCT_POL_LOW_AC,
        WCT_POL_ROUND
    } wct_policy_t;

    // Control engine register write
    typedef struct packed {
        logic valid;
        logic [3:0] sel;
        logic [1:0] idx;
        logic [TSF_W-1:0] data;
    } wct_wr_t;

    // Register selectors
    localparam logic [3:0] SEL_SIFS = 4'h0;
    localparam logic [3:0] SEL_RIFS = 4'h1;
    localparam logic [3:0] SEL_BKOFF = 4'h2;
    localparam logic [3:0] SEL_POLICY = 4'h3;
    localparam logic [3:0] SEL_SLEEP = 4'h4;
    localparam logic [3:0] SEL_TSF = 4'h5;
    localparam logic [3:0] SEL_BCN = 4'h6;
    localparam logic [3:0] SEL_TRIG = 4'h7;
    localparam logic [3:0] SEL_NAV = 4'h8;
    localparam logic [3:0] SEL_TBTT = 4'h9;
endpackage : wct_pkg

// File: rtl/wct_timing.sv
// Channel-access timing: interframe timers, backoff, sleep, TSF, NAV
`timescale 1ns/10ps
`default_nettype none
module wct_timing (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // PHY channel activity and slow clock tick (asynchronous pins)
    input wire logic phy_busy,
    input wire logic slow_tick,
    // Control engine register writes and commands
    input wire wct_pkg::wct_wr_t ctl_wr,
    input wire logic ps_enter,
    input wire logic nav_upd_en,
    input wire logic burst_mode,
    // Received frame information
    input wire logic rx_dur_vld,
    input wire logic [wct_pkg::NAV_W-1:0] rx_dur,
    input wire logic rx_ts_vld,
    input wire logic [wct_pkg::TSF_W-1:0] rx_ts,
    // Transmit engine side
    output logic ifs_go,
    output logic [wct_pkg::NUM_AC-1:0] bk_grant,
    output logic [wct_pkg::NUM_AC-1:0] ac_ready,
    output logic chan_idle,
    // Power save
    output logic mac_clk_en,
    output logic mac_suspended,
    // TSF and NAV outputs
    output logic [wct_pkg::TSF_W-1:0] tsf,
    output logic tbtt_pulse,
    output logic [wct_pkg::NUM_TRIG-1:0] trig_pulse,
    output logic nav_busy
);
    localparam int NA = wct_pkg::NUM_AC;
    localparam int CW = wct_pkg::CNT_W;
    localparam int TW = wct_pkg::TSF_W;

    // Synchronisers for pins
    logic [2:0] busy_s_q;
    logic [2:0] tick_s_q;
    logic busy_q;
    logic tick_prev_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_s_q <= 3'h0;
            tick_s_q <= 3'h0;
            busy_q <= 1'b0;
            tick_prev_q <= 1'b0;
        end else begin
            busy_s_q <= {busy_s_q[1:0], phy_busy};
            tick_s_q <= {tick_s_q[1:0], slow_tick};
            if (busy_s_q[2] == busy_s_q[1]) begin
                busy_q <= busy_s_q[2];
            end
            if (tick_s_q[2] == tick_s_q[1]) begin
                tick_prev_q <= tick_s_q[2];
            end
        end
    end
    logic tick_stable;
    assign tick_stable = (tick_s_q[2] == tick_s_q[1]) ? tick_s_q[2] : tick_prev_q;
    logic slow_edge;
    assign slow_edge = tick_stable & ~tick_prev_q;

    // Control engine registers
    logic [CW-1:0] sifs_q;
    logic [CW-1:0] rifs_q;
    logic [CW-1:0] bk_seed_q [NA];
    logic [NA-1:0] bk_load_q;
    wct_pkg::wct_policy_t policy_q;
    logic [TW-1:0] bcn_int_q;
    logic [TW-1:0] trig_off_q [wct_pkg::NUM_TRIG];
    logic [CW-1:0] sleep_load_q;
    logic sleep_load_vld_q;
    logic nav_wr_q;
    logic [wct_pkg::NAV_W-1:0] nav_wr_val_q;
    logic tsf_wr_q;
    logic tbtt_wr_q;
    logic [TW-1:0] wr_data_q;
    // Register write decode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sifs_q <= wct_pkg::SIFS_RST;
            rifs_q <= wct_pkg::RIFS_RST;
            for (int i = 0; i < NA; i++) begin
                bk_seed_q[i] <= wct_pkg::CNT_ZERO;
            end
            bk_load_q <= '0;
            policy_q <= wct_pkg::WCT_POL_HIGH_AC;
            bcn_int_q <= wct_pkg::BCN_RST;
            for (int i = 0; i < wct_pkg::NUM_TRIG; i++) begin
                trig_off_q[i] <= wct_pkg::TSF_ZERO;
            end
            sleep_load_q <= wct_pkg::CNT_ZERO;
            sleep_load_vld_q <= 1'b0;
            nav_wr_q <= 1'b0;
            nav_wr_val_q <= '0;
            tsf_wr_q <= 1'b0;
            tbtt_wr_q <= 1'b0;
            wr_data_q <= wct_pkg::TSF_ZERO;
        end else begin
            bk_load_q <= '0;
            sleep_load_vld_q <= 1'b0;
            nav_wr_q <= 1'b0;
            tsf_wr_q <= 1'b0;
            tbtt_wr_q <= 1'b0;
            wr_data_q <= ctl_wr.data;
            if (ctl_wr.valid) begin
                unique case (ctl_wr.sel)
                    wct_pkg::SEL_SIFS: sifs_q <= ctl_wr.data[CW-1:0];
                    wct_pkg::SEL_RIFS: rifs_q <= ctl_wr.data[CW-1:0];
                    wct_pkg::SEL_BKOFF: begin
                        bk_seed_q[ctl_wr.idx] <= ctl_wr.data[CW-1:0];
                        bk_load_q[ctl_wr.idx] <= 1'b1;
                    end
                    wct_pkg::SEL_POLICY: policy_q <= wct_pkg::wct_policy_t'(ctl_wr.data[1:0]);
                    wct_pkg::SEL_SLEEP: begin
                        sleep_load_q <= ctl_wr.data[CW-1:0];
                        sleep_load_vld_q <= 1'b1;
                    end
                    wct_pkg::SEL_TSF: tsf_wr_q <= 1'b1;
                    wct_pkg::SEL_BCN: bcn_int_q <= ctl_wr.data;
                    wct_pkg::SEL_TRIG: trig_off_q[ctl_wr.idx[0]] <= ctl_wr.data;
                    wct_pkg::SEL_NAV: begin
                        nav_wr_q <= 1'b1;
                        nav_wr_val_q <= ctl_wr.data[wct_pkg::NAV_W-1:0];
                    end
                    wct_pkg::SEL_TBTT: tbtt_wr_q <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // NAV timer, counts down in microseconds
    logic [wct_pkg::NAV_W-1:0] nav_q;
    logic [7:0] us_cnt_q;
    logic nav_busy_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nav_q <= '0;
            us_cnt_q <= 8'h00;
            nav_busy_q <= 1'b0;
        end else begin
            us_cnt_q <= (us_cnt_q == 8'(wct_pkg::US_CYC - 1)) ? 8'h00 : us_cnt_q + 8'h01;
            nav_busy_q <= (nav_q != '0);
            if (nav_wr_q) begin
                nav_q <= nav_wr_val_q;
            end else if (rx_dur_vld && nav_upd_en && rx_dur > nav_q) begin
                nav_q <= rx_dur;
            end else if (nav_q != '0 && us_cnt_q == 8'(wct_pkg::US_CYC - 1)) begin
                nav_q <= nav_q - 1'b1;
            end
        end
    end
    logic med_busy;
    assign med_busy = busy_q | (nav_q != '0);

    // Interframe timer restarted on end of activity
    logic busy_d1_q;
    logic [CW-1:0] ifs_cnt_q;
    logic ifs_run_q;
    logic ifs_go_q;
    logic idle_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Reset counts as end of activity so an idle medium gets an IFS
            busy_d1_q <= 1'b1;
            ifs_cnt_q <= wct_pkg::CNT_ZERO;
            ifs_run_q <= 1'b0;
            ifs_go_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            busy_d1_q <= med_busy;
            ifs_go_q <= 1'b0;
            if (med_busy) begin
                ifs_run_q <= 1'b0;
                idle_q <= 1'b0;
            end else if (busy_d1_q) begin
                ifs_cnt_q <= burst_mode ? rifs_q : sifs_q;
                ifs_run_q <= 1'b1;
            end else if (ifs_run_q) begin
                if (ifs_cnt_q <= 16'h0001) begin
                    ifs_run_q <= 1'b0;
                    ifs_go_q <= 1'b1;
                    idle_q <= 1'b1;
                end else begin
                    ifs_cnt_q <= ifs_cnt_q - 16'h0001;
                end
            end
        end
    end

    // Slot timer, free-running; slot marked idle only if IFS had elapsed and medium stayed idle all slot
    logic [15:0] slot_cnt_q;
    logic slot_idle_q;
    logic slot_end;
    assign slot_end = (slot_cnt_q == 16'(wct_pkg::SLOT_CYC - 1));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_cnt_q <= 16'h0000;
            slot_idle_q <= 1'b1;
        end else begin
            slot_cnt_q <= slot_end ? 16'h0000 : slot_cnt_q + 16'h0001;
            if (slot_end) begin
                slot_idle_q <= 1'b1;
            end else if (med_busy || !idle_q) begin
                slot_idle_q <= 1'b0;
            end
        end
    end

    // Backoff engines, one per access category
    logic [CW-1:0] bk_q [NA];
    logic [NA-1:0] bk_act_q;
    logic [NA-1:0] bk_zero;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NA; i++) begin
                bk_q[i] <= wct_pkg::CNT_ZERO;
            end
            bk_act_q <= '0;
        end else begin
            for (int i = 0; i < NA; i++) begin
                if (bk_load_q[i]) begin
                    bk_q[i] <= bk_seed_q[i];
                    bk_act_q[i] <= 1'b1;
                end else if (bk_grant[i]) begin
                    bk_act_q[i] <= 1'b0;
                end else if (bk_act_q[i] && slot_end && slot_idle_q && !med_busy && bk_q[i] != '0) begin
                    bk_q[i] <= bk_q[i] - 16'h0001;
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NA; i++) begin
            bk_zero[i] = bk_act_q[i] && bk_q[i] == '0 && idle_q && !med_busy;
        end
    end

    // Conflict resolution among expired engines
    logic [1:0] rr_q;
    logic [NA-1:0] win;
    always_comb begin
        win = '0;
        unique case (policy_q)
            wct_pkg::WCT_POL_HIGH_AC: begin
                for (int i = 0; i < NA; i++) begin
                    if (bk_zero[i]) win = '0;
                    if (bk_zero[i]) win[i] = 1'b1;
                end
            end
            wct_pkg::WCT_POL_LOW_AC: begin
                for (int i = NA - 1; i >= 0; i--) begin
                    if (bk_zero[i]) win = '0;
                    if (bk_zero[i]) win[i] = 1'b1;
                end
            end
            default: begin
                for (int k = NA - 1; k >= 0; k--) begin
                    if (bk_zero[2'(rr_q + 2'(k))]) begin
                        win = '0;
                        win[2'(rr_q + 2'(k))] = 1'b1;
                    end
                end
            end
        endcase
    end
    logic [NA-1:0] grant_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            grant_q <= '0;
            rr_q <= 2'h0;
        end else begin
            grant_q <= win & ~grant_q;
            if (win != '0) begin
                rr_q <= rr_q + 2'h1;
            end
        end
    end
    assign bk_grant = grant_q;

    // Sleep timer on slow ticks, gates the MAC clock
    logic [CW-1:0] sleep_cnt_q;
    logic [CW-1:0] sleep_dur_q;
    logic asleep_q;
    logic wake_q;
    logic clk_en_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_cnt_q <= wct_pkg::CNT_ZERO;
            sleep_dur_q <= wct_pkg::CNT_ZERO;
            asleep_q <= 1'b0;
            wake_q <= 1'b0;
            clk_en_q <= 1'b1;
        end else begin
            wake_q <= 1'b0;
            if (sleep_load_vld_q) begin
                sleep_cnt_q <= sleep_load_q;
                sleep_dur_q <= sleep_load_q;
            end else if (!asleep_q && ps_enter && sleep_cnt_q != '0) begin
                asleep_q <= 1'b1;
                clk_en_q <= 1'b0;
            end else if (asleep_q && slow_edge) begin
                if (sleep_cnt_q == 16'h0001) begin
                    asleep_q <= 1'b0;
                    clk_en_q <= 1'b1;
                    wake_q <= 1'b1;
                end
                sleep_cnt_q <= sleep_cnt_q - 16'h0001;
            end
        end
    end

    // TSF, TBTT and offset triggers
    logic [TW-1:0] tsf_q;
    logic [TW-1:0] tbtt_q;
    localparam int NUM_TRIG_W = wct_pkg::NUM_TRIG;
    logic [NUM_TRIG_W-1:0] trig_q;
    logic tbtt_q_p;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tsf_q <= wct_pkg::TSF_ZERO;
            tbtt_q <= wct_pkg::BCN_RST;
            trig_q <= '0;
            tbtt_q_p <= 1'b0;
        end else begin
            trig_q <= '0;
            tbtt_q_p <= 1'b0;
            if (tsf_wr_q) begin
                tsf_q <= wr_data_q;
            end else if (rx_ts_vld && nav_upd_en) begin
                tsf_q <= rx_ts;
            end else if (wake_q) begin
                tsf_q <= tsf_q + TW'(sleep_dur_q) * TW'(wct_pkg::US_NS / wct_pkg::CLK_NS);
            end else if (!asleep_q && us_cnt_q == 8'(wct_pkg::US_CYC - 1)) begin
                tsf_q <= tsf_q + 64'h1;
            end
            if (tbtt_wr_q) begin
                tbtt_q <= wr_data_q;
            end else if (tsf_q >= tbtt_q) begin
                tbtt_q <= tbtt_q + bcn_int_q;
                tbtt_q_p <= 1'b1;
            end
            for (int i = 0; i < wct_pkg::NUM_TRIG; i++) begin
                trig_q[i] <= (tsf_q == trig_off_q[i]) && us_cnt_q == 8'h00;
            end
        end
    end

    // Registered status outputs
    logic [NA-1:0] ac_ready_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ac_ready_q <= '0;
        end else begin
            ac_ready_q <= bk_act_q;
        end
    end
    assign ifs_go = ifs_go_q;
    assign ac_ready = ac_ready_q;
    assign chan_idle = idle_q;
    assign mac_clk_en = clk_en_q;
    assign mac_suspended = asleep_q;
    assign tsf = tsf_q;
    assign tbtt_pulse = tbtt_q_p;
    assign trig_pulse = trig_q;
    assign nav_busy = nav_busy_q;

    // Checks
    bk_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (med_busy && !(|bk_load_q)) |=> bk_q[0] == $past(bk_q[0])) else $error("backoff moved while busy");
    go_after_ifs_a: assert property (@(posedge clk) disable iff (!nrst)
        ifs_go |-> !$past(med_busy)) else $error("go while busy");
    one_grant_a: assert property (@(posedge clk) disable iff (!nrst)
        $onehot0(bk_grant)) else $error("multiple grants");
    clk_off_a: assert property (@(posedge clk) disable iff (!nrst)
        mac_suspended |-> !mac_clk_en) else $error("clock on while asleep");
    wake_tsf_a: assert property (@(posedge clk) disable iff (!nrst)
        wake_q && !tsf_wr_q && !(rx_ts_vld && nav_upd_en) |=> tsf_q > $past(tsf_q)) else $error("tsf not advanced");
    nav_load_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_dur_vld && nav_upd_en && !nav_wr_q && rx_dur > nav_q |=> nav_q == $past(rx_dur)) else $error("nav not loaded");
    nav_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_dur_vld && !nav_upd_en && !nav_wr_q && nav_q == '0 |=> nav_q == '0) else $error("nav updated undirected");
    ifs_start_a: assert property (@(posedge clk) disable iff (!nrst)
        !med_busy && busy_d1_q |=> ifs_run_q) else $error("ifs did not start");
endmodule : wct_timing
`default_nettype wire

// File: tb/wct_partner.sv
// Far-side model: PHY activity indication and slow sleep-clock source
`timescale 1ns/10ps
`default_nettype none
module wct_partner #(
    parameter int TICK_HALF = 10
) (
    // Bench side
    input wire logic clk,
    input wire logic busy_req,
    input wire logic tick_run,
    // Block side
    output logic phy_busy,
    output logic slow_tick
);
    logic busy_stage;
    logic tick_d;
    int tick_cnt;
    // Idle values at time zero
    initial begin
        phy_busy = 1'b0;
        slow_tick = 1'b0;
        busy_stage = 1'b0;
        tick_d = 1'b0;
        tick_cnt = 0;
    end
    // Request staged on the rising edge so the pin moves on the falling one
    always @(posedge clk) begin
        busy_stage <= busy_req;
    end
    always @(negedge clk) begin
        phy_busy <= busy_stage;
    end
    // Slow clock stands low unless the sleep window asks it to run
    always @(posedge clk) begin
        if (!tick_run) begin
            tick_cnt <= 0;
            tick_d <= 1'b0;
        end else if (tick_cnt == TICK_HALF - 1) begin
            tick_cnt <= 0;
            tick_d <= ~tick_d;
        end else begin
            tick_cnt <= tick_cnt + 1;
        end
    end
    always @(negedge clk) begin
        slow_tick <= tick_d;
    end
endmodule : wct_partner
`default_nettype wire

// File: tb/wct_timing_test.sv
// Self-checking bench for the channel-access timing block
`timescale 1ns/10ps
`default_nettype none
module wct_timing_test;
    typedef struct {
        int kind;
        logic [3:0] val;
        bit anyof;
        int lo;
        int hi;
    } wct_exp_t;
    localparam int S = wct_pkg::SLOT_CYC;
    localparam int US = wct_pkg::US_CYC;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic busy_req = 1'b0;
    logic tick_run = 1'b0;
    logic phy_busy, slow_tick, ps_enter, nav_upd_en, burst_mode, rx_dur_vld, rx_ts_vld;
    wct_pkg::wct_wr_t ctl_wr;
    logic [wct_pkg::NAV_W-1:0] rx_dur;
    logic [wct_pkg::TSF_W-1:0] rx_ts, tsf, ts;
    logic ifs_go, chan_idle, mac_clk_en, mac_suspended, tbtt_pulse, nav_busy;
    logic [wct_pkg::NUM_AC-1:0] bk_grant, ac_ready;
    logic [wct_pkg::NUM_TRIG-1:0] trig_pulse;
    wct_exp_t q[$];
    int cyc = 0;
    int n_mismatch = 0;
    int compares = 0;
    logic [31:0] rng = 32'h0001356e;
    int n;
    int k;

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    wct_partner u_far (.clk(clk), .busy_req(busy_req), .tick_run(tick_run), .phy_busy(phy_busy),
        .slow_tick(slow_tick));
    wct_timing u_dut (.clk(clk), .nrst(nrst), .phy_busy(phy_busy), .slow_tick(slow_tick), .ctl_wr(ctl_wr),
        .ps_enter(ps_enter), .nav_upd_en(nav_upd_en), .burst_mode(burst_mode), .rx_dur_vld(rx_dur_vld),
        .rx_dur(rx_dur), .rx_ts_vld(rx_ts_vld), .rx_ts(rx_ts), .ifs_go(ifs_go), .bk_grant(bk_grant),
        .ac_ready(ac_ready), .chan_idle(chan_idle), .mac_clk_en(mac_clk_en), .mac_suspended(mac_suspended),
        .tsf(tsf), .tbtt_pulse(tbtt_pulse), .trig_pulse(trig_pulse), .nav_busy(nav_busy));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic bad(input string msg);
        n_mismatch++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad

    task automatic cmp_lvl(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) bad(msg);
    endtask : cmp_lvl

    task automatic cmp_tsf(input logic [63:0] lo, input logic [63:0] hi, input string msg);
        compares++;
        if ((tsf >= lo && tsf <= hi) !== 1'b1) bad(msg);
    endtask : cmp_tsf

    task automatic cmp_evt(input wct_exp_t e, input logic [3:0] v);
        logic ok;
        compares++;
        ok = e.anyof ? ($onehot(v) && (v & ~e.val) == 4'h0) : (v === e.val);
        if (ok !== 1'b1 || cyc < e.lo || cyc > e.hi) bad("event value or timing");
    endtask : cmp_evt

    task automatic take(input int kind, input logic [3:0] v);
        if (q.size() > 0 && q[0].kind == kind) cmp_evt(q.pop_front(), v);
    endtask : take

    // Watcher: oldest note is compared whenever a pulse of its kind shows
    always @(negedge clk) begin
        if (nrst === 1'b1) begin
            if (bk_grant !== 4'h0) take(0, bk_grant);
            if (ifs_go !== 1'b0) take(1, {3'h0, ifs_go});
            if (trig_pulse !== 2'h0) take(2, {2'h0, trig_pulse});
        end
    end

    task automatic expect_evt(input int kind, input logic [3:0] v, input bit anyof, input int lo, input int hi);
        q.push_back('{kind, v, anyof, cyc + lo, cyc + hi});
    endtask : expect_evt

    task automatic drain(input int bound);
        int i;
        for (i = 0; i < bound && q.size() > 0; i++) @(negedge clk);
        if (q.size() > 0) begin
            bad("expected event missing");
            complete_run();
        end
    endtask : drain

    task automatic wr(input logic [3:0] sel, input logic [1:0] idx, input logic [63:0] data);
        @(negedge clk);
        ctl_wr = '{valid: 1'b1, sel: sel, idx: idx, data: data};
        @(negedge clk);
        ctl_wr.valid = 1'b0;
    endtask : wr

    // Idle inputs, reset for five cycles, idle outputs checked in reset
    task automatic do_reset();
        nrst = 1'b0;
        ctl_wr = '0;
        ps_enter = 1'b0;
        nav_upd_en = 1'b0;
        burst_mode = 1'b0;
        rx_dur_vld = 1'b0;
        rx_dur = '0;
        rx_ts_vld = 1'b0;
        rx_ts = '0;
        busy_req = 1'b0;
        tick_run = 1'b0;
        q.delete();
        repeat (5) @(negedge clk);
        cmp_lvl(|{ifs_go, bk_grant, ac_ready, trig_pulse, tbtt_pulse, nav_busy, mac_suspended}, 1'b0, "reset out");
        cmp_lvl(mac_clk_en, 1'b1, "reset clock enable");
        cmp_lvl(|tsf, 1'b0, "reset tsf");
        nrst = 1'b1;
    endtask : do_reset

    initial begin
        repeat (100000) @(posedge clk);
        bad("run limit");
        complete_run();
    end

    initial begin
        // Random seeds and categories, some held behind a busy medium
        for (int i = 0; i < 4; i++) begin
            do_reset();
            rng = xs(rng);
            n = 1 + int'(rng[4:3]);
            k = i[0] ? 2 : 0;
            busy_req = (k != 0);
            wr(wct_pkg::SEL_BKOFF, rng[1:0], 64'(n));
            expect_evt(0, 4'h1 << rng[1:0], 1'b0, (k + n - 1) * S, (k + n + 1) * S + 2000);
            repeat (k * S) @(negedge clk);
            busy_req = 1'b0;
            drain((n + 2) * S + 2500);
        end
        // Tie between two categories under each policy
        for (int p = 0; p < 3; p++) begin
            do_reset();
            wr(wct_pkg::SEL_POLICY, 2'h0, 64'(p));
            wr(wct_pkg::SEL_BKOFF, 2'h0, 64'h2);
            wr(wct_pkg::SEL_BKOFF, 2'h3, 64'h2);
            repeat (2) @(negedge clk);
            cmp_lvl(ac_ready === 4'h9, 1'b1, "armed engines");
            expect_evt(0, (p == 0) ? 4'h8 : (p == 1) ? 4'h1 : 4'h9, p == 2, S, 3 * S + 2000);
            drain(5 * S);
        end
        // Short and burst spacing after the medium goes quiet
        do_reset();
        wr(wct_pkg::SEL_SIFS, 2'h0, 64'd40);
        wr(wct_pkg::SEL_RIFS, 2'h0, 64'd16);
        for (int b = 0; b < 2; b++) begin
            burst_mode = b[0];
            busy_req = 1'b1;
            repeat (20) @(negedge clk);
            busy_req = 1'b0;
            expect_evt(1, 4'h1, 1'b0, b ? 16 : 40, (b ? 16 : 40) + 16);
            drain(200);
            cmp_lvl(chan_idle, 1'b1, "idle after ifs");
        end
        // Received duration defers backoff only when updates are allowed
        for (int h = 0; h < 2; h++) begin
            do_reset();
            nav_upd_en = h[0];
            rx_dur = 16'd60;
            rx_dur_vld = 1'b1;
            @(negedge clk);
            rx_dur_vld = 1'b0;
            wr(wct_pkg::SEL_BKOFF, 2'h0, 64'h1);
            cmp_lvl(nav_busy, h[0], "nav running");
            expect_evt(0, 4'h1, 1'b0, h * 6000, h * 6000 + 2 * S + 2000);
            drain(6000 + 3 * S + 2500);
        end
        // Timestamp adoption and offset triggers
        do_reset();
        nav_upd_en = 1'b1;
        rng = xs(rng);
        ts = {32'h1, rng};
        rx_ts = ts;
        rx_ts_vld = 1'b1;
        @(negedge clk);
        rx_ts_vld = 1'b0;
        repeat (3) @(negedge clk);
        cmp_tsf(ts, ts + 64'h1, "timestamp load");
        cmp_lvl(tbtt_pulse, 1'b1, "tbtt behind tsf");
        wr(wct_pkg::SEL_TRIG, 2'h0, ts + 64'h4);
        wr(wct_pkg::SEL_TRIG, 2'h1, ts + 64'h8);
        for (int j = 0; j < 2; j++) begin
            expect_evt(2, 4'h1 << j, 1'b0, (4 * j + 1) * US, (4 * j + 5) * US);
        end
        drain(12 * US);
        // Sleep for three slow ticks, then the time base moves on
        do_reset();
        wr(wct_pkg::SEL_TSF, 2'h0, 64'h1000);
        wr(wct_pkg::SEL_SLEEP, 2'h0, 64'h3);
        ps_enter = 1'b1;
        for (n = 0; n < 50 && mac_clk_en !== 1'b0; n++) @(negedge clk);
        cmp_lvl(mac_clk_en, 1'b0, "clock not stopped");
        cmp_lvl(mac_suspended, 1'b1, "not suspended");
        tick_run = 1'b1;
        for (n = 0; n < 200 && mac_clk_en !== 1'b1; n++) @(negedge clk);
        ps_enter = 1'b0;
        tick_run = 1'b0;
        cmp_lvl(n >= 40, 1'b1, "sleep too short");
        cmp_lvl(mac_clk_en, 1'b1, "clock not restored");
        cmp_lvl(mac_suspended, 1'b0, "still suspended");
        @(negedge clk);
        cmp_tsf(64'h1000 + 64'd300, 64'h1000 + 64'd302, "tsf after sleep");
        complete_run();
    end
endmodule : wct_timing_test
`default_nettype wire
